// ### include/pdc_pkg.sv
// Constants, field layout and carrier types for the device capability/control registers
package pdc_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] PDC_DEVCAP_OFS   = 12'h074;
  localparam logic [11:0] PDC_DEVCTL_OFS   = 12'h078;
  localparam logic [15:0] PDC_DEVCTL_RST   = 16'h2000;
  localparam logic [15:0] PDC_DEVCTL_WMASK = 16'hf4ff;
  localparam logic [2:0]  PDC_LAT_RST      = 3'h6;
  localparam logic [2:0]  PDC_MAX_READ_REQUEST_512     = 3'h2;

  // ---------------------------------------------------------------
  // Capability field positions and hardwired values
  // ---------------------------------------------------------------
  localparam int PDC_SCALE_LSB  = 26;
  localparam int PDC_VALUE_LSB  = 18;
  localparam int PDC_ROLE_BASED_ERR_REPORT_BIT   = 15;
  localparam int PDC_PIP_BIT    = 14;
  localparam int PDC_AIP_BIT    = 13;
  localparam int PDC_ABP_BIT    = 12;
  localparam int PDC_L1_LSB     = 9;
  localparam int PDC_L0S_LSB    = 6;
  localparam int PDC_EXT_TAG_SUPPORTED_BIT   = 5;
  localparam int PDC_PFS_LSB    = 3;
  localparam int PDC_MAX_PAYLOAD_SUPPORTED_LSB   = 0;
  localparam int PDC_MAX_READ_REQUEST_LSB   = 12;
  localparam int PDC_PL_SCALE_LSB = 8;
  localparam int PDC_PL_VALUE_LSB = 0;
  localparam logic        PDC_ROLE_BASED_ERR_REPORT_VAL = 1'b1;
  localparam logic        PDC_EXT_TAG_SUPPORTED_VAL = 1'b0;
  localparam logic [1:0]  PDC_PFS_VAL  = 2'h0;
  localparam logic [2:0]  PDC_MAX_PAYLOAD_SUPPORTED_VAL = 3'h2;

  // Power limit scale encoding: 1.0x, 0.1x, 0.01x, 0.001x
  typedef enum logic [1:0] {PDC_SCALE_X1, PDC_SCALE_X0P1, PDC_SCALE_X0P01, PDC_SCALE_X0P001} pdc_scale_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pdc_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pdc_cfg_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] payload;
  } pdc_spl_msg_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] l1;
    logic [2:0] l0s;
  } pdc_lat_wr_t;

endpackage

// ### verilog/pdc_regs.sv
// Device capability and device control register bank of the link capability structure
//
// Functional notes
// - Slot power message bits 9:8 set scale
// - Scale codes: 1.0x, 0.1x, 0.01x, 0.001x
// - Slot power message bits 7:0 set value
// - Expose value and scale for power product
// - Capability bits 31:28, 17:16 read zero
// - Capability bit 15 fixed at one
// - Capability bits 14:12 fixed at zero
// - Gen_ctrl_l1_lat mirrors general control 15:13
// - Gen_ctrl_l1_lat resets to 110b
// - Gen_ctrl_l0s_lat mirrors general control 18:16
// - Gen_ctrl_l0s_lat resets to 110b
// - Latency written below PHY exit latency is raised to it
// - Extended tag size reported unsupported
// - Phantom functions field reads 00b
// - Max payload supported reads 010b
// - Device control at 78h, resets 2000h
// - Read request size field resets to 512B
`timescale 1ns/100ps

module pdc_regs
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST_N,
  // Configuration access
  input  wire pdc_cfg_req_t CFG_REQ,
  output      pdc_cfg_rsp_t CFG_RSP,
  // Set slot power limit message
  input  wire pdc_spl_msg_t SPL_MSG,
  // General control latency writes and PHY exit latencies
  input  wire pdc_lat_wr_t  GEN_LAT_WR,
  input  wire logic [2:0]   PHY_L1_EXIT_LAT,
  input  wire logic [2:0]   PHY_L0S_EXIT_LAT,
  // Captured power limit and control outputs
  output      pdc_scale_t   SLOT_POWER_SCALE,
  output      logic [7:0]   SLOT_POWER_VALUE,
  output      logic [2:0]   MAX_READ_REQUEST,
  output      logic [15:0]  DEVICE_CONTROL
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] devctl;
    pdc_scale_t  scale;
    logic [7:0]  value;
    logic [2:0]  l1;
    logic [2:0]  l0s;
    logic        ack;
    logic [31:0] rdata;
  } pdc_state_t;

  pdc_state_t  st_r;
  pdc_state_t  st_nxt;
  logic [31:0] devcap;
  logic [15:0] lane_mask;
  logic        hit_cap;
  logic        hit_ctl;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Floor at the PHY exit latency; a smaller budget could never be met
  function automatic logic [2:0] pdc_floor(input logic [2:0] req, input logic [2:0] phy);
    pdc_floor = (req < phy) ? phy : req;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{CFG_REQ.be[gi]}};
    end
  endgenerate

  assign hit_cap = (CFG_REQ.addr == PDC_DEVCAP_OFS);
  assign hit_ctl = (CFG_REQ.addr == PDC_DEVCTL_OFS);

  // ---------------------------------------------------------------
  // Capability word assembly
  // ---------------------------------------------------------------
  always_comb begin
    devcap                                = '0;
    devcap[PDC_SCALE_LSB +: 2]            = st_r.scale;
    devcap[PDC_VALUE_LSB +: 8]            = st_r.value;
    devcap[PDC_ROLE_BASED_ERR_REPORT_BIT]                  = PDC_ROLE_BASED_ERR_REPORT_VAL;
    devcap[PDC_PIP_BIT]                   = 1'b0;
    devcap[PDC_AIP_BIT]                   = 1'b0;
    devcap[PDC_ABP_BIT]                   = 1'b0;
    devcap[PDC_L1_LSB +: 3]               = st_r.l1;
    devcap[PDC_L0S_LSB +: 3]              = st_r.l0s;
    devcap[PDC_EXT_TAG_SUPPORTED_BIT]                  = PDC_EXT_TAG_SUPPORTED_VAL;
    devcap[PDC_PFS_LSB +: 2]              = PDC_PFS_VAL;
    devcap[PDC_MAX_PAYLOAD_SUPPORTED_LSB +: 3]             = PDC_MAX_PAYLOAD_SUPPORTED_VAL;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = CFG_REQ.valid;
    // Reads answer from the pre-update state; unmapped offsets read zero
    st_nxt.rdata = '0;
    if (CFG_REQ.valid && !CFG_REQ.wr) begin
      if (hit_cap) begin
        st_nxt.rdata = devcap;
      end else if (hit_ctl) begin
        st_nxt.rdata = {16'h0000, st_r.devctl};
      end
    end
    // Only writable control bits under enabled lanes change
    if (CFG_REQ.valid && CFG_REQ.wr && hit_ctl) begin
      st_nxt.devctl = (st_r.devctl & ~(PDC_DEVCTL_WMASK & lane_mask))
                    | (CFG_REQ.wdata[15:0] & PDC_DEVCTL_WMASK & lane_mask);
    end
    // Capability writes fall through: the captured fields move only by message
    if (SPL_MSG.valid) begin
      st_nxt.scale = pdc_scale_t'(SPL_MSG.payload[PDC_PL_SCALE_LSB +: 2]);
      st_nxt.value = SPL_MSG.payload[PDC_PL_VALUE_LSB +: 8];
    end
    if (GEN_LAT_WR.valid) begin
      st_nxt.l1  = pdc_floor(GEN_LAT_WR.l1, PHY_L1_EXIT_LAT);
      st_nxt.l0s = pdc_floor(GEN_LAT_WR.l0s, PHY_L0S_EXIT_LAT);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r        <= '0;
      st_r.devctl <= PDC_DEVCTL_RST;
      st_r.scale  <= PDC_SCALE_X1;
      st_r.l1     <= PDC_LAT_RST;
      st_r.l0s    <= PDC_LAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign CFG_RSP.ack       = st_r.ack;
  assign CFG_RSP.rdata     = st_r.rdata;
  assign SLOT_POWER_SCALE  = st_r.scale;
  assign SLOT_POWER_VALUE  = st_r.value;
  assign MAX_READ_REQUEST  = st_r.devctl[PDC_MAX_READ_REQUEST_LSB +: 3];
  assign DEVICE_CONTROL    = st_r.devctl;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking pdc_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Request decode kept combinational; every flop lives in the state struct
  logic rd_cap;
  logic rd_ctl;
  logic wr_cap;
  logic wr_ctl;
  logic cfg_miss;

  assign rd_cap   = CFG_REQ.valid && !CFG_REQ.wr && hit_cap;
  assign rd_ctl   = CFG_REQ.valid && !CFG_REQ.wr && hit_ctl;
  assign wr_cap   = CFG_REQ.valid && CFG_REQ.wr && hit_cap;
  assign wr_ctl   = CFG_REQ.valid && CFG_REQ.wr && hit_ctl;
  assign cfg_miss = CFG_REQ.valid && !hit_cap && !hit_ctl;

  sequence s_spl;
    SPL_MSG.valid;
  endsequence

  // ---------------------------------------------------------------
  // Slot power capture
  // ---------------------------------------------------------------
  a_scale_capture: assert property (s_spl |=>
                     SLOT_POWER_SCALE == $past(SPL_MSG.payload[9:8]))
    else $error("Scale not captured from message bits 9:8");

  a_value_capture: assert property (s_spl |=>
                     SLOT_POWER_VALUE == $past(SPL_MSG.payload[7:0]))
    else $error("Value not captured from message bits 7:0");

  // Reads answer from the pre-update fields, hence the look one cycle back
  a_power_readback: assert property (rd_cap |=>
                      CFG_RSP.rdata[27:26] == $past(SLOT_POWER_SCALE) && CFG_RSP.rdata[25:18] == $past(SLOT_POWER_VALUE))
    else $error("Captured power fields not visible in capability word");

  a_power_hold: assert property (!SPL_MSG.valid |=>
                  $stable(SLOT_POWER_SCALE) && $stable(SLOT_POWER_VALUE))
    else $error("Captured power fields moved without a message");

  a_power_reset: assert property (@(posedge CLK) disable iff (1'b0)
                   !RST_N |=> SLOT_POWER_SCALE == PDC_SCALE_X1 && SLOT_POWER_VALUE == 8'h00)
    else $error("Captured power fields not cleared by reset");

  // ---------------------------------------------------------------
  // Hardwired capability bits
  // ---------------------------------------------------------------
  a_reserved_zero: assert property (rd_cap |=>
                     CFG_RSP.rdata[31:28] == 4'h0 && CFG_RSP.rdata[17:16] == 2'h0)
    else $error("Reserved capability bits not zero");

  a_rsvd_const: assert property (
                  devcap[31:28] == 4'h0 && devcap[17:16] == 2'h0)
    else $error("Reserved capability bits driven");

  a_fixed_bits: assert property (rd_cap |=>
                  CFG_RSP.rdata[15:12] == 4'h8 && CFG_RSP.rdata[5:0] == 6'h02)
    else $error("Hardwired capability bits wrong");

  a_role_based_err_report_set: assert property (
                devcap[15] == 1'b1)
    else $error("Role based error bit not set");

  a_no_indicators: assert property (rd_cap |=>
                     CFG_RSP.ack && CFG_RSP.rdata[14:12] == 3'h0)
    else $error("Indicator or button bits set");

  a_ind_zero: assert property (
                devcap[14:12] == 3'h0)
    else $error("Indicator or button bits driven");

  a_ext_tag: assert property (
               devcap[5] == 1'b0)
    else $error("Extended tag reported supported");

  a_phantom_zero: assert property (
                    devcap[4:3] == 2'h0)
    else $error("Phantom functions field not zero");

  a_max_payload_supported_fixed: assert property (
                  devcap[2:0] == 3'h2 && devcap[4:3] == 2'h0)
    else $error("Payload or phantom field wrong");

  // ---------------------------------------------------------------
  // Acceptable latency fields
  // ---------------------------------------------------------------
  a_l1_mirror: assert property (GEN_LAT_WR.valid && GEN_LAT_WR.l1 >= PHY_L1_EXIT_LAT |=>
                 devcap[11:9] == $past(GEN_LAT_WR.l1))
    else $error("Gen_ctrl_l1_lat does not follow general control");

  a_l0s_mirror: assert property (GEN_LAT_WR.valid && GEN_LAT_WR.l0s >= PHY_L0S_EXIT_LAT |=>
                  devcap[8:6] == $past(GEN_LAT_WR.l0s))
    else $error("Gen_ctrl_l0s_lat does not follow general control");

  // A budget below the PHY exit time could never be honoured, so it is raised
  a_lat_floor: assert property (GEN_LAT_WR.valid |=>
                 st_r.l1 >= $past(PHY_L1_EXIT_LAT) && st_r.l0s >= $past(PHY_L0S_EXIT_LAT))
    else $error("Latency set below PHY exit latency");

  a_l1_clamp: assert property (GEN_LAT_WR.valid && GEN_LAT_WR.l1 < PHY_L1_EXIT_LAT |=>
                devcap[11:9] == $past(PHY_L1_EXIT_LAT))
    else $error("Gen_ctrl_l1_lat not raised to PHY exit latency");

  a_l0s_clamp: assert property (GEN_LAT_WR.valid && GEN_LAT_WR.l0s < PHY_L0S_EXIT_LAT |=>
                 devcap[8:6] == $past(PHY_L0S_EXIT_LAT))
    else $error("Gen_ctrl_l0s_lat not raised to PHY exit latency");

  a_lat_hold: assert property (!GEN_LAT_WR.valid |=>
                $stable(devcap[11:6]))
    else $error("Latency fields moved without a general control write");

  // Reset checks watch reset itself and so are never disabled
  a_lat_reset: assert property (@(posedge CLK) disable iff (1'b0)
                 !RST_N ##1 RST_N |-> st_r.l1 == 3'h6 && st_r.l0s == 3'h6)
    else $error("Latency fields not 110b after reset");

  a_l0s_reset: assert property (@(posedge CLK) disable iff (1'b0)
                 !RST_N |=> devcap[8:6] == 3'h6)
    else $error("Gen_ctrl_l0s_lat not 110b after reset");

  // ---------------------------------------------------------------
  // Device control
  // ---------------------------------------------------------------
  a_ctl_reset: assert property (@(posedge CLK) disable iff (1'b0)
                 !RST_N |=> DEVICE_CONTROL == 16'h2000 && MAX_READ_REQUEST == 3'h2)
    else $error("Device control not 2000h after reset");

  a_ctl_readback: assert property (rd_ctl |=>
                    CFG_RSP.rdata == {16'h0000, $past(DEVICE_CONTROL)})
    else $error("Device control not returned at 78h");

  a_ctl_upper_zero: assert property (rd_ctl |=>
                      CFG_RSP.rdata[31:16] == 16'h0000)
    else $error("Upper half of control read not zero");

  a_max_read_request_hold: assert property (!(wr_ctl && CFG_REQ.be[1]) |=>
                 $stable(MAX_READ_REQUEST))
    else $error("Read request size changed without a write");

  a_ctl_hold: assert property (!wr_ctl |=>
                $stable(DEVICE_CONTROL))
    else $error("Device control changed without a write");

  a_ctl_low_lane: assert property (wr_ctl && CFG_REQ.be[0] |=>
                    DEVICE_CONTROL[7:0] == $past(CFG_REQ.wdata[7:0]))
    else $error("Low control byte not written");

  a_ctl_high_lane: assert property (wr_ctl && CFG_REQ.be[1] |=>
                     DEVICE_CONTROL[15:12] == $past(CFG_REQ.wdata[15:12]) && DEVICE_CONTROL[10] == $past(CFG_REQ.wdata[10]))
    else $error("High control byte not written");

  a_lane_off: assert property (wr_ctl && !CFG_REQ.be[1] |=>
                $stable(DEVICE_CONTROL[15:8]))
    else $error("Disabled control byte lane was written");

  a_ctl_ro_bits: assert property (
                   DEVICE_CONTROL[11] == 1'b0 && DEVICE_CONTROL[9:8] == 2'h0)
    else $error("Read-only control bits set");

  a_ro_ignored: assert property (wr_cap && !SPL_MSG.valid && !GEN_LAT_WR.valid |=>
                  $stable(devcap))
    else $error("Capability write altered read-only fields");

  // ---------------------------------------------------------------
  // Access handshake
  // ---------------------------------------------------------------
  a_ack_timing: assert property (CFG_REQ.valid |=>
                  CFG_RSP.ack)
    else $error("Configuration access not answered next cycle");

  a_ack_pulse: assert property (!CFG_REQ.valid |=>
                 !CFG_RSP.ack)
    else $error("Answer given without a request");

  a_wr_rdata_zero: assert property (CFG_REQ.valid && CFG_REQ.wr |=>
                     CFG_RSP.rdata == 32'h0000_0000)
    else $error("Write answered with nonzero data");

  a_miss_zero: assert property (cfg_miss |=>
                 CFG_RSP.rdata == 32'h0000_0000)
    else $error("Unmapped offset answered with nonzero data");

  a_rdata_idle: assert property (!CFG_REQ.valid |=>
                  CFG_RSP.rdata == 32'h0000_0000)
    else $error("Read data left standing after the answer");

  // ---------------------------------------------------------------
  // Scenario coverage
  // ---------------------------------------------------------------
  c_spl_min_scale: cover property (SPL_MSG.valid && SPL_MSG.payload[9:8] == 2'h3 ##[1:4] rd_cap);
  c_ctl_write:     cover property (wr_ctl ##[1:4] rd_ctl);
  c_lat_clamp:     cover property (GEN_LAT_WR.valid && GEN_LAT_WR.l1 < PHY_L1_EXIT_LAT);
  c_cap_write:     cover property (wr_cap);
  c_ctl_lane:      cover property (wr_ctl && !CFG_REQ.be[1]);

endmodule

// ### tb/pdc_host_model.sv
// Host model driving configuration accesses, power limit messages and latency writes
`timescale 1ns/100ps

module pdc_host_model
  import pdc_pkg::*;
(
  // Clock
  input  wire logic         CLK,
  // Requests toward the register bank
  output      pdc_cfg_req_t CFG_REQ,
  output      pdc_spl_msg_t SPL_MSG,
  output      pdc_lat_wr_t  GEN_LAT_WR,
  // PHY exit latency levels
  output      logic [2:0]   PHY_L1_EXIT_LAT,
  output      logic [2:0]   PHY_L0S_EXIT_LAT
);
  initial begin
    CFG_REQ = '0;
    SPL_MSG = '0;
    GEN_LAT_WR = '0;
    PHY_L1_EXIT_LAT = 3'h0;
    PHY_L0S_EXIT_LAT = 3'h0;
  end

  // Idle request fields other than valid are inverted so stale request data is never read as live
  task automatic cfg(input logic wr, input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd);
    @(posedge CLK);
    CFG_REQ <= '{valid: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
    @(posedge CLK);
    CFG_REQ <= '{valid: 1'b0, wr: ~wr, addr: ~addr, be: ~be, wdata: ~wd};
  endtask

  task automatic spl(input logic [9:0] p);
    @(posedge CLK);
    SPL_MSG <= '{valid: 1'b1, payload: p};
    @(posedge CLK);
    SPL_MSG <= '{valid: 1'b0, payload: ~p};
  endtask

  // Exit latencies stay level until the next call
  task automatic lat(input logic [2:0] l1, input logic [2:0] l0s, input logic [2:0] p1, input logic [2:0] p0);
    @(posedge CLK);
    PHY_L1_EXIT_LAT <= p1;
    PHY_L0S_EXIT_LAT <= p0;
    GEN_LAT_WR <= '{valid: 1'b1, l1: l1, l0s: l0s};
    @(posedge CLK);
    GEN_LAT_WR <= '{valid: 1'b0, l1: ~l1, l0s: ~l0s};
  endtask
endmodule

// ### tb/test_pdc_regs.sv
// Self-checking testbench for the device capability and control register bank
`timescale 1ns/100ps

module test_pdc_regs;
  import pdc_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  pdc_cfg_req_t cfg_req;
  pdc_cfg_rsp_t cfg_rsp;
  pdc_spl_msg_t spl_msg;
  pdc_lat_wr_t  gen_lat_wr;
  logic [2:0]   phy_l1, phy_l0s, mrr, wl1, wl0, p1, p0;
  pdc_scale_t   slot_scale;
  logic [7:0]   slot_value, val;
  logic [15:0]  dev_ctl;
  logic [1:0]   sc;
  logic [2:0]   l1, l0s;
  logic [31:0]  exp_q[$];
  int           fails = 0;
  int           checks_done = 0;
  int           cycles = 0;
  integer       seed = 32'h0290;

  always #2 clk = ~clk;

  pdc_regs dut (.CLK(clk), .RST_N(rst_n), .CFG_REQ(cfg_req), .CFG_RSP(cfg_rsp), .SPL_MSG(spl_msg),
    .GEN_LAT_WR(gen_lat_wr), .PHY_L1_EXIT_LAT(phy_l1), .PHY_L0S_EXIT_LAT(phy_l0s),
    .SLOT_POWER_SCALE(slot_scale), .SLOT_POWER_VALUE(slot_value), .MAX_READ_REQUEST(mrr),
    .DEVICE_CONTROL(dev_ctl));

  pdc_host_model host (.CLK(clk), .CFG_REQ(cfg_req), .SPL_MSG(spl_msg), .GEN_LAT_WR(gen_lat_wr),
    .PHY_L1_EXIT_LAT(phy_l1), .PHY_L0S_EXIT_LAT(phy_l0s));

  // ---------------------------------------------------------------
  // Expectations and comparison
  // ---------------------------------------------------------------
  function automatic logic [31:0] cap_word();
    return {4'h0, sc, val, 2'h0, 1'b1, 3'h0, l1, l0s, 1'b0, 2'h0, 3'h2};
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] e);
    exp_q.push_back(e);
    host.cfg(1'b0, addr, 4'hf, $random(seed));
  endtask

  // Writes are answered with zero data
  task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] d);
    exp_q.push_back(32'h0);
    host.cfg(1'b1, addr, be, d);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Answers are settled by the falling edge
  always @(negedge clk) begin
    if (cfg_rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unrequested answer", 32'h0, 32'h1);
      end else begin
        chk("answer data", exp_q.pop_front(), cfg_rsp.rdata);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    sc = 2'h0;
    val = 8'h0;
    l1 = 3'h6;
    l0s = 3'h6;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h074, cap_word());
    rd(12'h078, 32'h2000);
    chk("max read request", 32'h2, 32'(mrr));
    wr(12'h074, 4'hf, 32'hffffffff);
    rd(12'h074, cap_word());
    for (int k = 0; k < 4; k++) begin
      val = 8'($random(seed));
      sc = 2'(k);
      host.spl({sc, val});
      @(negedge clk);
      chk("power scale", 32'(sc), 32'(slot_scale));
      chk("power value", 32'(val), 32'(slot_value));
      rd(12'h074, cap_word());
    end
    for (int k = 0; k < 6; k++) begin
      wl1 = 3'($random(seed));
      wl0 = 3'($random(seed));
      p1 = 3'($random(seed));
      p0 = 3'($random(seed));
      host.lat(wl1, wl0, p1, p0);
      l1 = (wl1 > p1) ? wl1 : p1;
      l0s = (wl0 > p0) ? wl0 : p0;
      rd(12'h074, cap_word());
    end
    wr(12'h078, 4'h3, 32'h0000ffff);
    @(negedge clk);
    chk("device control", 32'hf4ff, 32'(dev_ctl));
    chk("max read request", 32'h7, 32'(mrr));
    wr(12'h078, 4'h1, 32'h0);
    rd(12'h078, 32'hf400);
    wr(12'h100, 4'hf, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h078, 32'hf400);
    // Reset again mid-run: every field must fall back to its reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sc = 2'h0;
    val = 8'h0;
    l1 = 3'h6;
    l0s = 3'h6;
    rd(12'h074, cap_word());
    rd(12'h078, 32'h2000);
    chk("max read request", 32'h2, 32'(mrr));
    repeat (3) @(posedge clk);
    chk("pending answers", 32'h0, 32'(exp_q.size()));
    finish_test();
  end
endmodule
